// ===== rtl/dcm_top.sv
// debug comparator target registers with their bus match outputs
// assumes a one-cycle register port and buses sampled on clock
//
// Strobed register access was decided locally.
`default_nettype none

module dcm_top #(
    parameter int NUM_CMP = 3
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic cpu_valid,
    input wire logic [17:0] cpu_addr,
    input wire logic [15:0] cpu_data,
    output logic armed,
    output logic [NUM_CMP-1:0] match
);
    // -------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_n_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    // -------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------
    function automatic logic is_addr_off(input logic [7:0] a);
        is_addr_off = (a == dcm_pkg::OFF_ADDR_HIGH) || (a == dcm_pkg::OFF_ADDR_MID) ||
                      (a == dcm_pkg::OFF_ADDR_LOW);
    endfunction

    function automatic logic is_data_off(input logic [7:0] a);
        is_data_off = (a >= dcm_pkg::OFF_DATA_HIGH) && (a <= dcm_pkg::OFF_MASK_LOW);
    endfunction

    // -------------------------------------------------------------
    // control registers
    // -------------------------------------------------------------
    logic armed_r;
    logic [1:0] sel_r;
    logic tag_a_r;

    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            armed_r <= 1'b0;
            sel_r <= dcm_pkg::RST_SEL;
        end else if (reg_wr && reg_addr == dcm_pkg::OFF_CTRL_ONE) begin
            armed_r <= reg_wdata[dcm_pkg::CTRL_ARM_BIT];
            sel_r <= reg_wdata[1:0];
        end
    end

    // tag option follows the same arming lock as the window
    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            tag_a_r <= 1'b0;
        end else if (reg_wr && !armed_r && reg_addr == dcm_pkg::OFF_CMP_A_OPT) begin
            tag_a_r <= reg_wdata[dcm_pkg::OPT_TAG_BIT];
        end
    end

    assign armed = armed_r;

    // -------------------------------------------------------------
    // window write qualification
    // -------------------------------------------------------------
    logic win_wr_ok;
    logic data_wr_ok;
    logic [3:0] data_wr;

    assign win_wr_ok = reg_wr && !armed_r && (sel_r != dcm_pkg::SEL_NONE);
    assign data_wr_ok = reg_wr && !armed_r && (sel_r == dcm_pkg::SEL_A);
    assign data_wr[0] = data_wr_ok && reg_addr == dcm_pkg::OFF_DATA_HIGH;
    assign data_wr[1] = data_wr_ok && reg_addr == dcm_pkg::OFF_DATA_LOW;
    assign data_wr[2] = data_wr_ok && reg_addr == dcm_pkg::OFF_MASK_HIGH;
    assign data_wr[3] = data_wr_ok && reg_addr == dcm_pkg::OFF_MASK_LOW;

    // -------------------------------------------------------------
    // comparators
    // -------------------------------------------------------------
    logic [17:0] target [NUM_CMP];
    logic [NUM_CMP-1:0] addr_hit;
    logic [15:0] data_target;
    logic [15:0] data_mask;
    logic data_ok;

    genvar i;
    generate
        for (i = 0; i < NUM_CMP; i++) begin : g_cmp
            logic this_sel;
            assign this_sel = win_wr_ok && (sel_r == 2'(i));
            dcm_addr_cmp u_addr (
                .clock(clock),
                .rst_n(rst_sync_n_r),
                .wr_high(this_sel && reg_addr == dcm_pkg::OFF_ADDR_HIGH),
                .wr_mid(this_sel && reg_addr == dcm_pkg::OFF_ADDR_MID),
                .wr_low(this_sel && reg_addr == dcm_pkg::OFF_ADDR_LOW),
                .wdata(reg_wdata),
                .bus_addr(cpu_addr),
                .target(target[i]),
                .hit(addr_hit[i])
            );
        end
    endgenerate

    // only comparator A carries a data stage
    dcm_data_cmp u_data (
        .clock(clock),
        .rst_n(rst_sync_n_r),
        .wr_en(data_wr),
        .wdata(reg_wdata),
        .tag(tag_a_r),
        .bus_data(cpu_data),
        .target(data_target),
        .mask(data_mask),
        .data_ok(data_ok)
    );

    // -------------------------------------------------------------
    // match outputs
    // -------------------------------------------------------------
    logic [NUM_CMP-1:0] match_nxt;
    logic [NUM_CMP-1:0] match_r;

    always_comb begin
        match_nxt = {NUM_CMP{cpu_valid}} & addr_hit;
        match_nxt[0] = match_nxt[0] && data_ok;
    end

    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            match_r <= '0;
        end else begin
            match_r <= match_nxt;
        end
    end

    assign match = match_r;

    // -------------------------------------------------------------
    // read path
    // -------------------------------------------------------------
    logic [7:0] rd_nxt;
    logic [7:0] rdata_r;
    logic [17:0] sel_target;

    assign sel_target = (sel_r == dcm_pkg::SEL_NONE) ? 18'h00000 : target[sel_r];

    always_comb begin
        rd_nxt = 8'h00;
        case (reg_addr)
            dcm_pkg::OFF_CTRL_ONE: rd_nxt = {armed_r, 5'h00, sel_r};
            dcm_pkg::OFF_CMP_A_OPT: rd_nxt = {7'h00, tag_a_r};
            dcm_pkg::OFF_STATUS: rd_nxt = {5'h00, match_r};
            dcm_pkg::OFF_ADDR_HIGH: rd_nxt = {6'h00, sel_target[17:16]};
            dcm_pkg::OFF_ADDR_MID: rd_nxt = sel_target[15:8];
            dcm_pkg::OFF_ADDR_LOW: rd_nxt = sel_target[7:0];
            default: rd_nxt = 8'h00;
        endcase
        if (is_data_off(reg_addr) && sel_r == dcm_pkg::SEL_A) begin
            case (reg_addr)
                dcm_pkg::OFF_DATA_HIGH: rd_nxt = data_target[15:8];
                dcm_pkg::OFF_DATA_LOW: rd_nxt = data_target[7:0];
                dcm_pkg::OFF_MASK_HIGH: rd_nxt = data_mask[15:8];
                default: rd_nxt = data_mask[7:0];
            endcase
        end
    end

    // data stand for exactly the cycle after the strobe
    always_ff @(posedge clock or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= reg_rd ? rd_nxt : 8'h00;
        end
    end

    assign reg_rdata = rdata_r;

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    armed_lock_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (armed_r && reg_wr && is_addr_off(reg_addr)) |=> $stable(sel_target))
        else $error("address target changed while armed");

    sel_none_rd_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_rd && sel_r == dcm_pkg::SEL_NONE && is_addr_off(reg_addr)) |=> reg_rdata == 8'h00)
        else $error("selector 11 read not zero");

    data_rd_gate_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_rd && sel_r != dcm_pkg::SEL_A && is_data_off(reg_addr)) |=> reg_rdata == 8'h00)
        else $error("data register visible off comparator A");

    high_zero_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_rd && reg_addr == dcm_pkg::OFF_ADDR_HIGH) |=> reg_rdata[7:2] == 6'h00)
        else $error("address high upper bits not zero");

    low_write_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && !armed_r && sel_r == dcm_pkg::SEL_B && reg_addr == dcm_pkg::OFF_ADDR_LOW)
        |=> target[1][7:0] == $past(reg_wdata))
        else $error("comparator B low target not written");

    data_wr_gate_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && (armed_r || sel_r != dcm_pkg::SEL_A) && is_data_off(reg_addr))
        |=> $stable(data_target) && $stable(data_mask))
        else $error("data register written without access");

    mid_readback_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_rd && sel_r == dcm_pkg::SEL_C && reg_addr == dcm_pkg::OFF_ADDR_MID)
        |=> reg_rdata == $past(target[2][15:8]))
        else $error("mid target readback wrong");

    tag_ignores_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (cpu_valid && tag_a_r && cpu_addr == target[0]) |=> match[0])
        else $error("tagged comparator A missed address match");

    mask_gate_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (cpu_valid && !tag_a_r && cpu_addr == target[0] && ((cpu_data ^ data_target) & data_mask) != 16'h0000)
        |=> !match[0])
        else $error("masked data mismatch still matched");

    addr_match_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (cpu_valid && cpu_addr != target[1]) |=> !match[1])
        else $error("comparator B matched a wrong address");

    rd_idle_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside the read answer cycle");

    // -------------------------------------------------------------
    // register write and read checks
    // -------------------------------------------------------------
    // each write check looks one edge on, where the stored copy has just moved
    a_mid_write_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && !armed_r && sel_r == dcm_pkg::SEL_A && reg_addr == dcm_pkg::OFF_ADDR_MID)
        |=> target[0][15:8] == $past(reg_wdata))
        else $error("comparator A mid target not written");

    c_high_write_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && !armed_r && sel_r == dcm_pkg::SEL_C && reg_addr == dcm_pkg::OFF_ADDR_HIGH)
        |=> target[2][17:16] == $past(reg_wdata[1:0]))
        else $error("comparator C high target not written");

    other_cmp_hold_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && sel_r == dcm_pkg::SEL_B && is_addr_off(reg_addr))
        |=> $stable(target[0]) && $stable(target[2]))
        else $error("write to comparator B touched another target");

    none_wr_drop_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && sel_r == dcm_pkg::SEL_NONE && is_addr_off(reg_addr))
        |=> $stable(target[0]) && $stable(target[1]) && $stable(target[2]))
        else $error("selector 11 write reached a target");

    data_high_wr_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && !armed_r && sel_r == dcm_pkg::SEL_A && reg_addr == dcm_pkg::OFF_DATA_HIGH)
        |=> data_target[15:8] == $past(reg_wdata))
        else $error("data high target not written");

    data_low_wr_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && !armed_r && sel_r == dcm_pkg::SEL_A && reg_addr == dcm_pkg::OFF_DATA_LOW)
        |=> data_target[7:0] == $past(reg_wdata))
        else $error("data low target not written");

    mask_high_wr_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && !armed_r && sel_r == dcm_pkg::SEL_A && reg_addr == dcm_pkg::OFF_MASK_HIGH)
        |=> data_mask[15:8] == $past(reg_wdata))
        else $error("data high mask not written");

    mask_low_wr_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && !armed_r && sel_r == dcm_pkg::SEL_A && reg_addr == dcm_pkg::OFF_MASK_LOW)
        |=> data_mask[7:0] == $past(reg_wdata))
        else $error("data low mask not written");

    arm_bit_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && reg_addr == dcm_pkg::OFF_CTRL_ONE)
        |=> armed == $past(reg_wdata[dcm_pkg::CTRL_ARM_BIT]))
        else $error("arm bit did not follow control write");

    tag_lock_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_wr && armed_r && reg_addr == dcm_pkg::OFF_CMP_A_OPT) |=> $stable(tag_a_r))
        else $error("tag select changed while armed");

    a_low_read_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_rd && sel_r == dcm_pkg::SEL_A && reg_addr == dcm_pkg::OFF_ADDR_LOW)
        |=> reg_rdata == $past(target[0][7:0]))
        else $error("comparator A low target readback wrong");

    mask_read_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (reg_rd && sel_r == dcm_pkg::SEL_A && reg_addr == dcm_pkg::OFF_MASK_HIGH)
        |=> reg_rdata == $past(data_mask[15:8]))
        else $error("data high mask readback wrong");

    // -------------------------------------------------------------
    // match checks
    // -------------------------------------------------------------
    // only A has a data stage, so B and C must match on the address alone
    valid_gate_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        !cpu_valid |=> match == '0)
        else $error("match without a valid bus cycle");

    b_no_data_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (cpu_valid && cpu_addr == target[1]) |=> match[1])
        else $error("comparator B missed an address match");

    c_exact_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (cpu_valid && cpu_addr == target[2]) |=> match[2])
        else $error("comparator C missed an address match");

    mask_pass_a: assert property (@(posedge clock) disable iff (!rst_sync_n_r)
        (cpu_valid && !tag_a_r && cpu_addr == target[0] && ((cpu_data ^ data_target) & data_mask) == 16'h0000)
        |=> match[0])
        else $error("masked data agreement not matched");

    arm_cover_c: cover property (@(posedge clock) disable iff (!rst_sync_n_r)
        armed_r && reg_wr && is_addr_off(reg_addr));
    match_a_cover_c: cover property (@(posedge clock) disable iff (!rst_sync_n_r)
        match[0] && !tag_a_r && data_mask != 16'h0000);
    match_c_cover_c: cover property (@(posedge clock) disable iff (!rst_sync_n_r)
        match[2]);
    none_rd_cover_c: cover property (@(posedge clock) disable iff (!rst_sync_n_r)
        reg_rd && sel_r == dcm_pkg::SEL_NONE && is_addr_off(reg_addr));
    tag_cover_c: cover property (@(posedge clock) disable iff (!rst_sync_n_r)
        match[0] && tag_a_r);
endmodule

`default_nettype wire

// ===== rtl/dcm_pkg.sv
// constants for the debug comparator target registers
// assumes an 8-bit register port and 18/16-bit processor buses
//
// Overview of operation
// - selector 00/01/10 picks A/B/C, 11 none
// - shared window spans offsets 0x28 to 0x2F
// - selected address targets readable at any time
// - address target writes ignored while armed
// - high target holds address bits 17:16 only
// - mid target holds address bits 15:8
// - low target holds address bits 7:0
// - data target and mask exist for A only
// - data registers readable only with selector 00
// - data writes need selector 00 and disarmed
// - data high target matches data bits 15:8
// - data low target matches data bits 7:0
// - target bit compared only when mask set
// - tagging on comparator A ignores data compare
// - high mask resets zero, gates bits 15:8
// - low mask gates bits 7:0, same limits
// - arm bit in control one arms unit
`default_nettype none

package dcm_pkg;
    // -------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL_ONE = 8'h20;
    localparam logic [7:0] OFF_CMP_A_OPT = 8'h21;
    localparam logic [7:0] OFF_STATUS = 8'h22;
    localparam logic [7:0] OFF_WIN_FIRST = 8'h28;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h29;
    localparam logic [7:0] OFF_ADDR_MID = 8'h2A;
    localparam logic [7:0] OFF_ADDR_LOW = 8'h2B;
    localparam logic [7:0] OFF_DATA_HIGH = 8'h2C;
    localparam logic [7:0] OFF_DATA_LOW = 8'h2D;
    localparam logic [7:0] OFF_MASK_HIGH = 8'h2E;
    localparam logic [7:0] OFF_MASK_LOW = 8'h2F;
    // -------------------------------------------------------------
    // fields
    // -------------------------------------------------------------
    localparam int CTRL_ARM_BIT = 7;
    localparam int OPT_TAG_BIT = 0;
    localparam int ADDR_HIGH_W = 2;
    localparam logic [1:0] SEL_A = 2'h0;
    localparam logic [1:0] SEL_B = 2'h1;
    localparam logic [1:0] SEL_C = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;
    // -------------------------------------------------------------
    // reset values
    // -------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_SEL = 2'h0;
endpackage

`default_nettype wire

// ===== rtl/dcm_addr_cmp.sv
// one comparator's 18-bit address target and its bus match
// assumes write enables are already qualified by selector and arming
`default_nettype none

module dcm_addr_cmp (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_high,
    input wire logic wr_mid,
    input wire logic wr_low,
    input wire logic [7:0] wdata,
    input wire logic [17:0] bus_addr,
    output logic [17:0] target,
    output logic hit
);
    logic [1:0] high_r;
    logic [7:0] mid_r;
    logic [7:0] low_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            high_r <= dcm_pkg::RST_SEL;
            mid_r <= dcm_pkg::RST_BYTE;
            low_r <= dcm_pkg::RST_BYTE;
        end else begin
            if (wr_high) begin
                high_r <= wdata[dcm_pkg::ADDR_HIGH_W-1:0];
            end
            if (wr_mid) begin
                mid_r <= wdata;
            end
            if (wr_low) begin
                low_r <= wdata;
            end
        end
    end

    assign target = {high_r, mid_r, low_r};
    // each stored bit names the level the bus bit must have
    assign hit = (bus_addr == target);
endmodule

`default_nettype wire

// ===== rtl/dcm_data_cmp.sv
// comparator A data targets and masks with masked data match
// assumes write enables are already qualified by selector and arming
`default_nettype none

module dcm_data_cmp (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] wr_en,
    input wire logic [7:0] wdata,
    input wire logic tag,
    input wire logic [15:0] bus_data,
    output logic [15:0] target,
    output logic [15:0] mask,
    output logic data_ok
);
    // index 0..3: data high, data low, mask high, mask low
    logic [7:0] regs_r [4];

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_reg
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    regs_r[g] <= dcm_pkg::RST_BYTE;
                end else if (wr_en[g]) begin
                    regs_r[g] <= wdata;
                end
            end
        end
    endgenerate

    assign target = {regs_r[0], regs_r[1]};
    assign mask = {regs_r[2], regs_r[3]};
    // masked-out bits always agree; tagging skips the data check
    assign data_ok = tag || (((bus_data ^ target) & mask) == 16'h0000);
endmodule

`default_nettype wire

// ===== tb/dcm_cpu_model.sv
// processor bus model: presents one bus cycle at a time to the comparators
// assumes its task is entered just after a rising clock edge
`default_nettype none

module dcm_cpu_model (
    input wire logic clock,
    output logic cpu_valid,
    output logic [17:0] cpu_addr,
    output logic [15:0] cpu_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cpu_valid = 1'b0;
        cpu_addr = 18'h0;
        cpu_data = 16'h0;
    end

    // -------------------------------------------------------------
    // bus cycle, optionally after idle cycles
    // -------------------------------------------------------------
    // idle buses keep toggling so a stale address never looks valid
    task automatic cycle(input logic [17:0] a, input logic [15:0] d, input int gap);
        repeat (gap) begin
            cpu_addr <= ~cpu_addr;
            cpu_data <= ~cpu_data;
            @(posedge clock);
        end
        cpu_valid <= 1'b1;
        cpu_addr <= a;
        cpu_data <= d;
        @(posedge clock);
        cpu_valid <= 1'b0;
        cpu_addr <= ~a;
        cpu_data <= ~d;
    endtask
endmodule

`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the debug comparator target registers
// assumes dcm_cpu_model drives the processor buses, 4 ns clock
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rexp;} dcm_reg_row_t;
    typedef struct {logic [17:0] addr; logic [15:0] data; int gap; logic [2:0] mexp;} dcm_bus_row_t;
    logic clock;
    logic rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic cpu_valid;
    logic [17:0] cpu_addr;
    logic [15:0] cpu_data;
    logic armed;
    logic [2:0] match;
    int mismatches;
    int samples_checked;
    // comparator A targets: address 2A55A, data 3CC3, mask F00F
    dcm_reg_row_t reg_rows [10] = '{'{8'h29, 8'hFF, 8'h03}, '{8'h2A, 8'hA5, 8'hA5}, '{8'h2B, 8'h5A, 8'h5A},
        '{8'h2C, 8'h3C, 8'h3C}, '{8'h2D, 8'hC3, 8'hC3}, '{8'h2E, 8'hF0, 8'hF0}, '{8'h2F, 8'h0F, 8'h0F},
        '{8'h28, 8'hFF, 8'h00}, '{8'h30, 8'hFF, 8'h00}, '{8'h29, 8'h02, 8'h02}};
    dcm_bus_row_t bus_rows [9] = '{'{18'h2A55A, 16'h3CC3, 0, 3'h1}, '{18'h2A55A, 16'h3DC3, 1, 3'h1},
        '{18'h2A55A, 16'h2CC3, 0, 3'h0}, '{18'h2A55A, 16'h3CC2, 0, 3'h0}, '{18'h2A55B, 16'h3CC3, 0, 3'h0},
        '{18'h2A45A, 16'h3CC3, 0, 3'h0}, '{18'h3A55A, 16'h3CC3, 2, 3'h0}, '{18'h01122, 16'h0000, 0, 3'h2},
        '{18'h13344, 16'hFFFF, 1, 3'h4}};

    dcm_top #(.NUM_CMP(3)) dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr),
        .cpu_data(cpu_data), .armed(armed), .match(match));
    dcm_cpu_model cpu (.clock(clock), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .cpu_data(cpu_data));

    // -------------------------------------------------------------
    // register port and compare tasks
    // -------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        samples_checked++;
        if (reg_rdata !== exp) begin
            mismatches++;
            $display("CHECK FAILED reg %h expected %h seen %h", a, exp, reg_rdata);
        end
        @(posedge clock);
    endtask

    task automatic bus_chk(input dcm_bus_row_t r);
        cpu.cycle(r.addr, r.data, r.gap);
        @(negedge clock);
        samples_checked++;
        if (match !== r.mexp) begin
            mismatches++;
            $display("CHECK FAILED match at %h expected %h seen %h", r.addr, r.mexp, match);
        end
        @(posedge clock);
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        give_verdict();
    end

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        do_reset();
        rd_chk(8'h29, 8'h00);
        rd_chk(8'h2E, 8'h00);
        foreach (reg_rows[i]) begin
            wr(reg_rows[i].addr, reg_rows[i].wdata);
            rd_chk(reg_rows[i].addr, reg_rows[i].rexp);
        end
        // comparator B then C, then the unmapped selector value
        wr(8'h20, 8'h01);
        wr(8'h2A, 8'h11);
        wr(8'h2B, 8'h22);
        wr(8'h2C, 8'h77);
        rd_chk(8'h2A, 8'h11);
        rd_chk(8'h2C, 8'h00);
        wr(8'h20, 8'h02);
        wr(8'h29, 8'h01);
        wr(8'h2A, 8'h33);
        wr(8'h2B, 8'h44);
        wr(8'h20, 8'h03);
        wr(8'h2A, 8'h99);
        rd_chk(8'h2A, 8'h00);
        rd_chk(8'h29, 8'h00);
        wr(8'h20, 8'h02);
        rd_chk(8'h2A, 8'h33);
        wr(8'h20, 8'h00);
        rd_chk(8'h2A, 8'hA5);
        rd_chk(8'h2C, 8'h3C);
        foreach (bus_rows[i]) begin
            bus_chk(bus_rows[i]);
        end
        // tagging on comparator A drops the data compare
        bus_chk(bus_rows[2]);
        wr(8'h21, 8'h01);
        bus_rows[2].mexp = 3'h1;
        bus_chk(bus_rows[2]);
        wr(8'h21, 8'h00);
        // armed: reads still work, target writes dropped
        wr(8'h20, 8'h80);
        rd_chk(8'h20, 8'h80);
        wr(8'h2A, 8'h00);
        wr(8'h2E, 8'h00);
        wr(8'h2F, 8'hFF);
        rd_chk(8'h2A, 8'hA5);
        rd_chk(8'h2E, 8'hF0);
        rd_chk(8'h2F, 8'h0F);
        wr(8'h20, 8'h81);
        wr(8'h2B, 8'h00);
        rd_chk(8'h2B, 8'h22);
        bus_chk(bus_rows[7]);
        // reset in mid-run clears targets, masks and arming
        do_reset();
        rd_chk(8'h20, 8'h00);
        rd_chk(8'h2A, 8'h00);
        rd_chk(8'h2E, 8'h00);
        give_verdict();
    end
endmodule

`default_nettype wire
